// file: hw/meter_event_bank.sv
// apb register bank: peak voltage capture and sticky primary event flags
// assumes event inputs are synchronous to pclk; pulses last one cycle
// Overview of operation
// (R1) peak register holds largest unsigned voltage magnitude
// (R2) magnitude is the sample shifted right five
// (R3) bits 26:24 tag phases producing the peak
// (R4) only selected channels join peak detection
// (R5) bit 25 sets on new temperature result
// (R6) bit 24 sets when current sum comparison flips
// (R7) bit 23 sets on resampled buffer full while cap_sel is clear
// (R8) bit 22 sets on enabled trigger event
// (R9) bit 21 sets on distortion/pf refresh
// (R10) bit 20 sets on multicycle rms update
// (R11) bit 19 sets on half-cycle rms update
// (R12) bit 18 sets on power accumulation update
// (R13) bit 17 sets on enabled page fill while cap_sel is clear
// (R14) bit 16 sets when buffer stops after trigger while cap_sel is clear
// (R15) bit 15 sets on new waveform samples
// (R16) bits 14:11 set on energy pulse falling
// (R17) flags reset zero, sticky, write one clears
// (R18) reserved bits read zero, ignore writes
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module meter_event_bank
   import meter_status_pkg::*;
(
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic [ADDR_W-1:0]               paddr,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [31:0]                     pwdata,
   output logic [31:0]                          prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   input  wire logic                            sample_valid,
   input  wire logic [PHASES-1:0][SAMPLE_W-1:0] phase_voltage_sample,
   input  wire logic                            temp_result_pulse,
   input  wire logic                            current_sum_above,
   input  wire logic                            resampled_full_pulse,
   input  wire logic                            trigger_event_pulse,
   input  wire logic                            distortion_pf_pulse,
   input  wire logic                            multicycle_rms_pulse,
   input  wire logic                            halfcycle_rms_pulse,
   input  wire logic                            power_accum_pulse,
   input  wire logic [PAGES-1:0]                page_fill_pulse,
   input  wire logic                            buffer_stop_pulse,
   input  wire logic                            new_samples_pulse,
   input  wire logic [CF_N-1:0]                 energy_pulse_out
);
   typedef struct packed {
      logic [31:0]      flags;
      logic [PSEL_W-1:0] peak_sel;
      logic             cap_sel;
      logic [PAGES-1:0] page_mask;
      logic             cmp_prev;
      logic             cmp_seen;
      logic [CF_N-1:0]  cf_prev;
      logic [31:0]      rdata;
      logic             ready;
      logic             slverr;
   } bank_state_t;

   bank_state_t       st_r;
   bank_state_t       st_nxt;
   logic [31:0]       ev;
   logic [31:0]       clear;
   logic [CF_N-1:0]   cf_fall;
   logic              setup;
   logic              wr_hit;
   peak_if            pk ();

   peak_tracker u_peak (
      .pclk                 (pclk),
      .presetn              (presetn),
      .sample_valid         (sample_valid),
      .phase_voltage_sample (phase_voltage_sample),
      .pk                   (pk)
   );

   assign pk.channel_en = st_r.peak_sel; // [R4]

   genvar g;
   generate
      for (g = 0; g < CF_N; g++) begin : g_cf
         assign cf_fall[g] = st_r.cf_prev[g] & ~energy_pulse_out[g]; // [R16]
      end
   endgenerate

   assign setup  = psel && !penable && !st_r.ready;
   // writes land at the completing access edge only
   assign wr_hit = psel && penable && st_r.ready && pwrite;
   assign clear  = (wr_hit && paddr == EVENT_ADDR) ? (pwdata & EVENT_MASK) : 32'h0; // [R17]

   always_comb begin
      ev                = 32'h0;
      ev[TEMP_BIT]      = temp_result_pulse; // [R5]
      // first sample after reset only primes the comparison history
      ev[MISM_BIT]      = st_r.cmp_seen && (current_sum_above != st_r.cmp_prev); // [R6]
      ev[FULL_BIT]      = resampled_full_pulse && !st_r.cap_sel; // [R7]
      ev[TRIG_BIT]      = trigger_event_pulse; // [R8]
      ev[THD_BIT]       = distortion_pf_pulse; // [R9]
      ev[RMS1012_BIT]   = multicycle_rms_pulse; // [R10]
      ev[RMSHALF_BIT]   = halfcycle_rms_pulse; // [R11]
      ev[PWR_BIT]       = power_accum_pulse; // [R12]
      ev[PAGE_BIT]      = !st_r.cap_sel && |(page_fill_pulse & st_r.page_mask); // [R13]
      ev[STOP_BIT]      = !st_r.cap_sel && buffer_stop_pulse; // [R14]
      ev[DRDY_BIT]      = new_samples_pulse; // [R15]
      ev[CF1_BIT +: CF_N] = cf_fall; // [R16]
   end

   always_comb begin
      st_nxt          = st_r;
      st_nxt.cmp_prev = current_sum_above;
      st_nxt.cmp_seen = 1'b1;
      st_nxt.cf_prev  = energy_pulse_out;
      // set wins over a same-cycle clear
      st_nxt.flags    = ((st_r.flags & ~clear) | ev) & EVENT_MASK; // [R17] [R18]
      if (wr_hit && paddr == CFG3_ADDR) begin
         st_nxt.peak_sel = pwdata[PSEL_LSB +: PSEL_W];
      end
      if (wr_hit && paddr == WAVEFORM_BUFFER_CONFIG_ADDR) begin
         st_nxt.cap_sel   = pwdata[CAP_SEL_BIT];
         st_nxt.page_mask = pwdata[PMASK_LSB +: PAGES];
      end
      if (setup) begin
         st_nxt.ready  = 1'b1;
         st_nxt.slverr = 1'b0;
         st_nxt.rdata  = 32'h0;
         unique case (paddr)
            PEAK_ADDR: begin
               st_nxt.rdata[MAG_LSB +: MAG_W] = pk.magnitude; // [R1]
               st_nxt.rdata[TAG_LSB +: 3]     = pk.tag; // [R3]
            end
            EVENT_ADDR: begin
               st_nxt.rdata = st_r.flags & EVENT_MASK; // [R18]
            end
            CFG3_ADDR: begin
               st_nxt.rdata[PSEL_LSB +: PSEL_W] = st_r.peak_sel;
            end
            WAVEFORM_BUFFER_CONFIG_ADDR: begin
               st_nxt.rdata[CAP_SEL_BIT]        = st_r.cap_sel;
               st_nxt.rdata[PMASK_LSB +: PAGES] = st_r.page_mask;
            end
            default: begin
               st_nxt.slverr = 1'b1;
            end
         endcase
      end else if (st_r.ready) begin
         st_nxt.ready  = 1'b0;
         st_nxt.slverr = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{flags: EVENT_RST, peak_sel: PSEL_RST, cap_sel: CAP_SEL_RST,
                   page_mask: PMASK_RST, cmp_prev: 1'b0, cmp_seen: 1'b0,
                   cf_prev: 4'h0, rdata: 32'h0, ready: 1'b0, slverr: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata  = st_r.rdata;
   assign pready  = st_r.ready;
   assign pslverr = st_r.slverr;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_flags_sticky: assert property ( // [R17]
      1 |=> ((($past(st_r.flags) & ~$past(clear)) & ~st_r.flags) == 32'h0))
      else $error("event flag dropped without a clear");
   a_temp_set: assert property ( // [R5]
      temp_result_pulse |=> st_r.flags[TEMP_BIT])
      else $error("temperature flag not set");
   a_mismatch_set: assert property ( // [R6]
      (st_r.cmp_seen && $changed(current_sum_above)) |-> ##1 st_r.flags[MISM_BIT])
      else $error("mismatch flag not set on comparison change");
   a_full_gated: assert property ( // [R7]
      (resampled_full_pulse && !st_r.cap_sel) |=> st_r.flags[FULL_BIT])
      else $error("buffer full flag not set");
   a_page_set: assert property ( // [R13]
      (!st_r.cap_sel && |(page_fill_pulse & st_r.page_mask)) |=> st_r.flags[PAGE_BIT])
      else $error("page flag not set");
   a_stop_gated: assert property ( // [R14]
      (!$past(st_r.flags[STOP_BIT]) && !$past(buffer_stop_pulse && !st_r.cap_sel))
      |-> !st_r.flags[STOP_BIT])
      else $error("stop flag set without qualified event");
   a_cf_fall: assert property ( // [R16]
      (energy_pulse_out[0] ##1 !energy_pulse_out[0]) |=> st_r.flags[CF1_BIT])
      else $error("energy pulse flag not set on falling edge");
   a_reserved_zero: assert property ( // [R18]
      (st_r.flags & ~EVENT_MASK) == 32'h0 && (st_r.rdata[31:27] == 5'h0 || st_r.slverr))
      else $error("reserved bits not zero");
   a_apb_answer: assert property (
      (psel && !penable && !st_r.ready) |=> pready)
      else $error("no answer one cycle after setup");

   // handshake shape: one answer cycle per setup, refusals carry no data
   a_ready_pulse: assert property (
      pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_cause: assert property (
      pready |-> $past(psel && !penable))
      else $error("pready without a preceding setup");
   a_err_with_ready: assert property (
      pslverr |-> pready)
      else $error("pslverr outside an answer cycle");
   a_err_unmapped: assert property (
      (setup && paddr != PEAK_ADDR && paddr != EVENT_ADDR && paddr != CFG3_ADDR
         && paddr != WAVEFORM_BUFFER_CONFIG_ADDR) |=> pslverr)
      else $error("unmapped access not refused");
   a_err_no_data: assert property (
      pslverr |-> (prdata == 32'h0))
      else $error("refused access returned data");
   a_rdata_hold: assert property (
      !setup |=> $stable(prdata))
      else $error("read data changed without a setup");

   // read data is the snapshot taken at the setup edge
   a_flags_read: assert property ( // [R17]
      (setup && paddr == EVENT_ADDR) |=> prdata == $past(st_r.flags))
      else $error("flag read differs from stored flags");
   a_peak_read: assert property ( // [R1]
      (setup && paddr == PEAK_ADDR) |=> prdata[MAG_LSB +: MAG_W] == $past(pk.magnitude))
      else $error("peak read differs from tracker");
   a_tag_read: assert property ( // [R3]
      (setup && paddr == PEAK_ADDR) |=> prdata[TAG_LSB +: 3] == $past(pk.tag))
      else $error("phase tag read differs from tracker");
   a_tag_present: assert property ( // [R3]
      (pk.magnitude != 24'h0) |-> (pk.tag != 3'h0))
      else $error("stored peak has no phase tag");

   // configuration words change only through their own writes
   a_sel_write: assert property ( // [R4]
      (wr_hit && paddr == CFG3_ADDR) |=> st_r.peak_sel == $past(pwdata[PSEL_LSB +: PSEL_W]))
      else $error("channel select write lost");
   a_sel_hold: assert property ( // [R4]
      !(wr_hit && paddr == CFG3_ADDR) |=> $stable(st_r.peak_sel))
      else $error("channel select changed without a write");
   a_capture_write: assert property ( // [R7]
      (wr_hit && paddr == WAVEFORM_BUFFER_CONFIG_ADDR) |=> st_r.cap_sel == $past(pwdata[CAP_SEL_BIT]))
      else $error("capture select write lost");
   a_mask_write: assert property ( // [R13]
      (wr_hit && paddr == WAVEFORM_BUFFER_CONFIG_ADDR)
      |=> st_r.page_mask == $past(pwdata[PMASK_LSB +: PAGES]))
      else $error("page mask write lost");
   a_wfb_hold: assert property ( // [R13]
      !(wr_hit && paddr == WAVEFORM_BUFFER_CONFIG_ADDR) |=> $stable({st_r.cap_sel, st_r.page_mask}))
      else $error("buffer settings changed without a write");

   // each event input sets its flag at the next edge whatever the bus does; buffer stop only while cap_sel is clear
   a_trig_set: assert property ( // [R8]
      trigger_event_pulse |=> st_r.flags[TRIG_BIT])
      else $error("trigger flag not set");
   a_thd_set: assert property ( // [R9]
      distortion_pf_pulse |=> st_r.flags[THD_BIT])
      else $error("distortion flag not set");
   a_multi_rms_set: assert property ( // [R10]
      multicycle_rms_pulse |=> st_r.flags[RMS1012_BIT])
      else $error("multicycle rms flag not set");
   a_half_rms_set: assert property ( // [R11]
      halfcycle_rms_pulse |=> st_r.flags[RMSHALF_BIT])
      else $error("half-cycle rms flag not set");
   a_power_set: assert property ( // [R12]
      power_accum_pulse |=> st_r.flags[PWR_BIT])
      else $error("power flag not set");
   a_stop_set: assert property ( // [R14]
      (buffer_stop_pulse && !st_r.cap_sel) |=> st_r.flags[STOP_BIT])
      else $error("buffer stop flag not set");
   a_samples_set: assert property ( // [R15]
      new_samples_pulse |=> st_r.flags[DRDY_BIT])
      else $error("new samples flag not set");

   // gated and masked sources must stay quiet
   a_full_blocked: assert property ( // [R7]
      (st_r.cap_sel && !st_r.flags[FULL_BIT]) |=> !st_r.flags[FULL_BIT])
      else $error("buffer full flag set in resampled mode");
   a_page_blocked: assert property ( // [R13]
      (st_r.cap_sel && !st_r.flags[PAGE_BIT]) |=> !st_r.flags[PAGE_BIT])
      else $error("page flag set in resampled mode");
   a_page_masked: assert property ( // [R13]
      (!st_r.flags[PAGE_BIT] && !(|(page_fill_pulse & st_r.page_mask))) |=> !st_r.flags[PAGE_BIT])
      else $error("page flag set by a masked page");
   a_mismatch_quiet: assert property ( // [R6]
      (!st_r.flags[MISM_BIT] && !(st_r.cmp_seen && $changed(current_sum_above)))
      |=> !st_r.flags[MISM_BIT])
      else $error("mismatch flag set without a comparison change");
   a_cf_quiet: assert property ( // [R16]
      (!st_r.flags[CF1_BIT + CF_N - 1]
         && !($past(energy_pulse_out[CF_N - 1]) && !energy_pulse_out[CF_N - 1]))
      |=> !st_r.flags[CF1_BIT + CF_N - 1])
      else $error("energy flag set without a falling edge");

   // write one clears, write zero keeps, a same-cycle event wins
   a_clear_works: assert property ( // [R17]
      (wr_hit && paddr == EVENT_ADDR && ev == 32'h0)
      |=> (st_r.flags & $past(pwdata) & EVENT_MASK) == 32'h0)
      else $error("written one did not clear its flag");
   a_set_wins: assert property ( // [R17]
      (wr_hit && paddr == EVENT_ADDR) |=> (st_r.flags & $past(ev)) == $past(ev))
      else $error("clear masked a same-cycle event");

   c_flag_cleared: cover property (st_r.flags[TEMP_BIT] ##1 !st_r.flags[TEMP_BIT]);
   c_set_and_clear: cover property (temp_result_pulse && clear[TEMP_BIT]);
   c_unmapped: cover property (pready && pslverr);
   c_peak_read: cover property (pready && paddr == PEAK_ADDR && pk.tag != 3'h0);
   c_full_blocked: cover property (st_r.cap_sel && resampled_full_pulse);
endmodule
`default_nettype wire

// file: hw/peak_tracker.sv
// tracks the largest voltage magnitude over enabled phases with a phase tag
// assumes samples are two's complement and sample_valid is a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none
module peak_tracker
   import meter_status_pkg::*;
(
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          sample_valid,
   input  wire logic [PHASES-1:0][SAMPLE_W-1:0] phase_voltage_sample,
   peak_if.tracker                            pk
);
   typedef struct packed {
      logic [MAG_W-1:0] mag;
      logic [2:0]       tag;
   } peak_state_t;

   peak_state_t            st_r;
   peak_state_t            st_nxt;
   logic [PHASES-1:0][MAG_W-1:0] mag;
   logic [MAG_W-1:0]       best;
   logic [2:0]             best_tag;

   genvar g;
   generate
      for (g = 0; g < PHASES; g++) begin : g_mag
         logic [SAMPLE_W-1:0] absval;
         logic [SAMPLE_W-1:0] shifted;
         assign absval  = phase_voltage_sample[g][SAMPLE_W-1] ?
                          (~phase_voltage_sample[g] + 32'h1) : phase_voltage_sample[g];
         assign shifted = absval >> PEAK_SHIFT; // [R2]
         // saturate rather than wrap if the shifted value overflows 24 bits
         assign mag[g]  = (|shifted[SAMPLE_W-1:MAG_W]) ? {MAG_W{1'b1}} : shifted[MAG_W-1:0];
      end
   endgenerate

   always_comb begin
      st_nxt   = st_r;
      best     = '0;
      best_tag = '0;
      for (int i = 0; i < PHASES; i++) begin
         if (pk.channel_en[i] && mag[i] > best) begin // [R4]
            best = mag[i];
         end
      end
      for (int i = 0; i < PHASES; i++) begin
         best_tag[i] = pk.channel_en[i] && (mag[i] == best); // [R3]
      end
      if (sample_valid && |pk.channel_en) begin
         if (best > st_r.mag) begin // [R1]
            st_nxt.mag = best;
            st_nxt.tag = best_tag;
         end else if (best == st_r.mag && best != '0) begin
            st_nxt.tag = st_r.tag | best_tag;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{mag: PEAK_RST, tag: 3'h0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pk.magnitude = st_r.mag;
   assign pk.tag       = st_r.tag;

   a_peak_monotone: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      1 |=> st_r.mag >= $past(st_r.mag))
      else $error("peak magnitude decreased");
   a_peak_disabled: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      (sample_valid && pk.channel_en == 3'h0) |=> $stable(st_r))
      else $error("peak changed with no channel enabled");
endmodule
`default_nettype wire

// file: inc/meter_status_pkg.sv
// constants for the peak voltage capture and primary event flag bank
// assumes a 32-bit apb slave; printed offsets are word indices
package meter_status_pkg;
   localparam int unsigned   ADDR_W       = 16;
   localparam logic [11:0]   PEAK_IDX     = 12'h401;
   localparam logic [11:0]   EVENT_IDX    = 12'h402;
   localparam logic [11:0]   CFG3_IDX     = 12'h410;
   localparam logic [11:0]   WAVEFORM_BUFFER_CONFIG_IDX  = 12'h411;
   localparam logic [15:0]   PEAK_ADDR    = {2'b00, PEAK_IDX, 2'b00};
   localparam logic [15:0]   EVENT_ADDR   = {2'b00, EVENT_IDX, 2'b00};
   localparam logic [15:0]   CFG3_ADDR    = {2'b00, CFG3_IDX, 2'b00};
   localparam logic [15:0]   WAVEFORM_BUFFER_CONFIG_ADDR = {2'b00, WAVEFORM_BUFFER_CONFIG_IDX, 2'b00};

   localparam int unsigned   PHASES       = 3;
   localparam int unsigned   SAMPLE_W     = 32;
   localparam int unsigned   MAG_W        = 24;
   localparam int unsigned   MAG_LSB      = 0;
   localparam int unsigned   TAG_LSB      = 24;
   localparam int unsigned   PEAK_SHIFT   = 5;

   localparam int unsigned   PSEL_LSB     = 2;
   localparam int unsigned   PSEL_W       = 3;
   localparam logic [2:0]    PSEL_RST     = 3'h7;
   localparam int unsigned   CAP_SEL_BIT  = 0;
   localparam logic          CAP_SEL_RST  = 1'b0;
   localparam int unsigned   PAGES        = 16;
   localparam int unsigned   PMASK_LSB    = 16;
   localparam logic [15:0]   PMASK_RST    = 16'h0000;

   localparam int unsigned   TEMP_BIT     = 25;
   localparam int unsigned   MISM_BIT     = 24;
   localparam int unsigned   FULL_BIT     = 23;
   localparam int unsigned   TRIG_BIT     = 22;
   localparam int unsigned   THD_BIT      = 21;
   localparam int unsigned   RMS1012_BIT  = 20;
   localparam int unsigned   RMSHALF_BIT  = 19;
   localparam int unsigned   PWR_BIT      = 18;
   localparam int unsigned   PAGE_BIT     = 17;
   localparam int unsigned   STOP_BIT     = 16;
   localparam int unsigned   DRDY_BIT     = 15;
   localparam int unsigned   CF1_BIT      = 11;
   localparam int unsigned   CF_N         = 4;
   localparam logic [31:0]   EVENT_MASK   = 32'h03ff_f800;
   localparam logic [31:0]   EVENT_RST    = 32'h0000_0000;
   localparam logic [23:0]   PEAK_RST     = 24'h00_0000;
endpackage

// file: inc/peak_if.sv
// carries channel enables down to the peak tracker and its result back up
// assumes both ends run on the bank clock
`timescale 1ns/1ps
`default_nettype none
interface peak_if;
   logic [2:0]  channel_en;
   logic [23:0] magnitude;
   logic [2:0]  tag;
   modport tracker (input channel_en, output magnitude, output tag);
   modport bank    (output channel_en, input magnitude, input tag);
endinterface
`default_nettype wire

// file: verification/test_meter_event_bank.sv
// self-checking bench for the peak capture and primary event flag bank
// assumes the bank answers every apb access through pready
`timescale 1ns/1ps
`default_nettype none
module test_meter_event_bank
   import meter_status_pkg::*;
;
   logic                            pclk, presetn, psel, penable, pwrite;
   logic [ADDR_W-1:0]               paddr;
   logic [31:0]                     pwdata, prdata, rdat;
   logic                            pready, pslverr, rerr;
   logic                            sample_valid, current_sum_above;
   logic [PHASES-1:0][SAMPLE_W-1:0] smp;
   logic [8:0]                      ev;
   logic [PAGES-1:0]                page;
   logic [CF_N-1:0]                 cf;
   int                              err_total, comparisons;
   int                              bitpos [9] = '{25, 23, 22, 21, 20, 19, 18, 16, 15};

   meter_event_bank dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_valid(sample_valid), .phase_voltage_sample(smp),
      .temp_result_pulse(ev[0]), .current_sum_above(current_sum_above),
      .resampled_full_pulse(ev[1]), .trigger_event_pulse(ev[2]),
      .distortion_pf_pulse(ev[3]), .multicycle_rms_pulse(ev[4]),
      .halfcycle_rms_pulse(ev[5]), .power_accum_pulse(ev[6]), .page_fill_pulse(page),
      .buffer_stop_pulse(ev[7]), .new_samples_pulse(ev[8]), .energy_pulse_out(cf));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task end_sim();
      if (err_total == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
      end
   endtask

   task chk_err(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: pslverr %b, wanted %b", $time, got, exp);
      end
   endtask

   // request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk_err(rerr, 1'b0);
   endtask

   task rd(input logic [15:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, exp);
      chk_err(rerr, 1'b0);
   endtask

   task pulse_ev(input int i);
      @(posedge pclk);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev[i] <= 1'b0;
   endtask

   task pulse_page(input int i);
      @(posedge pclk);
      page[i] <= 1'b1;
      @(posedge pclk);
      page[i] <= 1'b0;
   endtask

   task smpl(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
      @(posedge pclk);
      smp <= {c, b, a};
      sample_valid <= 1'b1;
      @(posedge pclk);
      sample_valid <= 1'b0;
   endtask

   initial begin
      #400us;
      err_total++;
      end_sim();
   end

   initial begin
      {psel, penable, pwrite, sample_valid, current_sum_above} = '0;
      paddr = '0;
      pwdata = '0;
      smp = '0;
      ev = '0;
      page = '0;
      cf = '0;
      err_total = 0;
      comparisons = 0;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(PEAK_ADDR, 32'h0000_0000);
      rd(EVENT_ADDR, 32'h0000_0000);
      apb(1'b0, 16'h0ffc, 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
      chk_err(rerr, 1'b1);
      // zero write must leave the flag, one write must clear it
      for (int i = 0; i < 9; i++) begin
         pulse_ev(i);
         wr(EVENT_ADDR, 32'h0000_0000);
         rd(EVENT_ADDR, 32'h1 << bitpos[i]);
         wr(EVENT_ADDR, 32'h1 << bitpos[i]);
         rd(EVENT_ADDR, 32'h0000_0000);
      end
      for (int i = 0; i < 2; i++) begin
         @(posedge pclk);
         current_sum_above <= ~current_sum_above;
         @(posedge pclk);
         rd(EVENT_ADDR, 32'h0100_0000);
         wr(EVENT_ADDR, 32'h0100_0000);
      end
      for (int i = 0; i < CF_N; i++) begin
         @(posedge pclk);
         cf[i] <= 1'b1;
         @(posedge pclk);
         rd(EVENT_ADDR, 32'h0000_0000);
         cf[i] <= 1'b0;
         @(posedge pclk);
         rd(EVENT_ADDR, 32'h1 << (CF1_BIT + i));
         wr(EVENT_ADDR, 32'h1 << (CF1_BIT + i));
      end
      pulse_ev(0);
      wr(EVENT_ADDR, 32'hfdff_ffff);
      rd(EVENT_ADDR, 32'h0200_0000);
      wr(EVENT_ADDR, 32'h0200_0000);
      // event lands at the same edge as the clearing write: the event wins
      fork
         wr(EVENT_ADDR, 32'h0200_0000);
         begin
            repeat (2) @(posedge pclk);
            ev[0] <= 1'b1;
            @(posedge pclk);
            ev[0] <= 1'b0;
         end
      join
      rd(EVENT_ADDR, 32'h0200_0000);
      wr(EVENT_ADDR, 32'h0200_0000);
      pulse_page(5);
      rd(EVENT_ADDR, 32'h0000_0000);
      wr(WAVEFORM_BUFFER_CONFIG_ADDR, 32'h0020_0000);
      pulse_page(4);
      rd(EVENT_ADDR, 32'h0000_0000);
      pulse_page(5);
      rd(EVENT_ADDR, 32'h0002_0000);
      wr(EVENT_ADDR, 32'h0002_0000);
      // resampled capture mode: page, full and stop flags stay quiet
      wr(WAVEFORM_BUFFER_CONFIG_ADDR, 32'h0020_0001);
      rd(WAVEFORM_BUFFER_CONFIG_ADDR, 32'h0020_0001);
      pulse_page(5);
      pulse_ev(1);
      pulse_ev(7);
      pulse_ev(2);
      rd(EVENT_ADDR, 32'h0040_0000);
      wr(EVENT_ADDR, 32'h0040_0000);
      wr(WAVEFORM_BUFFER_CONFIG_ADDR, 32'h0000_0000);
      smpl(32'hffff_e000, 32'h0000_4000, 32'h0000_1000);
      rd(PEAK_ADDR, 32'h0200_0200);
      wr(CFG3_ADDR, 32'h0000_0004);
      rd(CFG3_ADDR, 32'h0000_0004);
      smpl(32'h0000_8000, 32'h0010_0000, 32'h0000_0000);
      rd(PEAK_ADDR, 32'h0100_0400);
      wr(CFG3_ADDR, 32'h0000_001c);
      smpl(32'h0000_8000, 32'h0000_0000, 32'hffff_8000);
      rd(PEAK_ADDR, 32'h0500_0400);
      wr(PEAK_ADDR, 32'hffff_ffff);
      rd(PEAK_ADDR, 32'h0500_0400);
      // oversized magnitude saturates at the 24-bit ceiling
      wr(CFG3_ADDR, 32'h0000_0008);
      smpl(32'h0000_0000, 32'h7fff_ffff, 32'h0000_0000);
      rd(PEAK_ADDR, 32'h02ff_ffff);
      // reset in mid-run returns flags, peak and select to their start values
      pulse_ev(8);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(EVENT_ADDR, 32'h0000_0000);
      rd(PEAK_ADDR, 32'h0000_0000);
      rd(CFG3_ADDR, 32'h0000_001c);
      end_sim();
   end
endmodule
`default_nettype wire
